// file: rtl/vid_defines.vh
`ifndef VID_DEFINES_VH
`define VID_DEFINES_VH

// Clock and timing
`define CLK_PERIOD_NS 16'h0005
`define SLEW_STEP_NS 16'h03E8
`define SLEW_STEP_CYC ((`SLEW_STEP_NS + `CLK_PERIOD_NS - 16'h0001) / `CLK_PERIOD_NS)
`define PHASE_PERIOD_NS 16'h07D0
`define PHASE_PERIOD_CYC (`PHASE_PERIOD_NS / `CLK_PERIOD_NS)
`define PHASE_DUTY_NS 16'h01F4
`define PHASE_DUTY_CYC (`PHASE_DUTY_NS / `CLK_PERIOD_NS)

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_TARGET 8'h04
`define REG_SLEW 8'h08
`define REG_TIMING 8'h0C
`define REG_STATUS 8'h10

// Control fields
`define CTRL_PHASE_LSB 0
`define CTRL_PHASE_MSB 1
`define CTRL_AUX_EN 2
`define CTRL_RESET 32'h0000_0006

// Phase count selections
`define PHASES_2 2'h0
`define PHASES_3 2'h1
`define PHASES_4 2'h2

// Code pin roles
`define PIN_MODE_SENSE 1
`define PIN_SERIAL_CLK 2
`define PIN_SERIAL_DATA 3

// Reference in 12.5 mV units
`define REF_OFF 8'h00
`define REF_HI_BASE 8'h7C
`define REF_LO_BASE 8'h5D
`define PAR_HALF 6'h20
`define FIX_REF_00 8'h70
`define FIX_REF_01 8'h60
`define FIX_REF_10 8'h50
`define FIX_REF_11 8'h40

`endif

// file: rtl/ref_slew.v
`include "vid_defines.vh"
`default_nettype none
module ref_slew (
   input wire i_clk,
   input wire i_rst_b,
   input wire [7:0] i_target,
   input wire [15:0] i_step_cycles,
   output reg [7:0] o_ref,
   output wire o_busy
);

   reg [15:0] tick;

   assign o_busy = (o_ref != i_target);

   // Move one step toward the target each step interval
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tick <= 16'h0000;
         o_ref <= `REF_OFF;
      end else if (!o_busy) begin
         tick <= 16'h0000;
      end else if (tick + 16'h0001 >= i_step_cycles) begin
         tick <= 16'h0000;
         if (o_ref < i_target) begin
            o_ref <= o_ref + 8'h01;
         end else begin
            o_ref <= o_ref - 8'h01;
         end
      end else begin
         tick <= tick + 16'h0001;
      end
   end

endmodule
`default_nettype wire

// file: rtl/phase_gen.v
`include "vid_defines.vh"
`default_nettype none
module phase_gen (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_run,
   input wire [1:0] i_phase_sel,
   input wire [15:0] i_period,
   input wire [15:0] i_duty,
   output reg [3:0] o_phase
);

   reg [15:0] cnt;
   reg [15:0] off1;
   reg [15:0] off2;
   reg [15:0] off3;
   reg [3:0] used;
   reg [3:0] next_phase;

   // Position of the counter within a slot that starts at an offset
   function on_time;
      input [15:0] c;
      input [15:0] off;
      input [15:0] p;
      input [15:0] d;
      reg [15:0] pos;
      begin
         pos = (c >= off) ? (c - off) : (c + p - off);
         on_time = (pos < d);
      end
   endfunction

   // Free-running slot counter
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt <= 16'h0000;
      end else if (!i_run || cnt + 16'h0001 >= i_period) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   // Stagger offsets and active outputs per phase count
   always @* begin
      off1 = 16'h0000;
      off2 = 16'h0000;
      off3 = 16'h0000;
      used = 4'b1111;
      case (i_phase_sel)
         `PHASES_2: begin
            // RL8 two phase map
            used = 4'b0101;
            // RL10 180 degree spacing
            off2 = i_period >> 1;
         end
         `PHASES_3: begin
            // RL9 three phase map
            used = 4'b0111;
            // RL10 120 degree spacing
            off1 = i_period / 16'h0003;
            off2 = (i_period / 16'h0003) << 1;
         end
         default: begin
            // RL10 90 degree spacing
            off1 = i_period >> 2;
            off2 = i_period >> 1;
            off3 = (i_period >> 2) + (i_period >> 1);
         end
      endcase
      next_phase[0] = on_time(cnt, 16'h0000, i_period, i_duty);
      next_phase[1] = on_time(cnt, off1, i_period, i_duty);
      next_phase[2] = on_time(cnt, off2, i_period, i_duty);
      next_phase[3] = on_time(cnt, off3, i_period, i_duty);
      next_phase = next_phase & used & {4{i_run}};
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_phase <= 4'b0000;
      end else begin
         o_phase <= next_phase;
      end
   end

endmodule
`default_nettype wire

// file: rtl/vid_mode_select_decode.v
// Overview of operation
// RL1 - Enable rising edge samples mode sense pin: 1 parallel, 0 serial.
// RL2 - Parallel mode takes core reference from the 6-bit code bus.
// RL3 - Parallel mode keeps auxiliary plane high impedance, no switching.
// RL4 - Parallel mode ignores host power ok input.
// RL5 - Serial mode ignores pins 0,4,5; pin 2 clock, pin 3 data.
// RL6 - Codes 0 to 31: 1.55 V down 25 mV per step.
// RL7 - Codes 32 to 63: 0.7625 V down 12.5 mV per step.
// RL8 - Two phases drive outputs 1 and 3; 2 and 4 held low.
// RL9 - Three phases drive 1 to 3; four phases drive all.
// RL10 - Active phases evenly spaced: 180, 120 or 90 degrees.
// RL11 - Auxiliary timebase free-runs at 1.25 times core phase frequency; code uses 1.25 times the core period (0.8 times frequency).
// RL12 - Fixed debug mode uses clock and data as static 2-bit code.
// RL13 - Code changes move reference on the fly at limited slew.
// RL14 - Fixed codes: 00 1.4, 01 1.2, 10 1.0, 11 0.8 V.
// RL15 - Fixed debug entered while select low, regardless of power ok.
// RL16 - Selected mode holds until next enable rising edge or reset.
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "vid_defines.vh"
`default_nettype none
module vid_mode_select_decode (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   input wire i_enable,
   input wire [5:0] i_parallel_code_bus,
   input wire i_host_power_ok,
   input wire i_fixed_debug_select_n,
   output wire o_phase_out_1,
   output wire o_phase_out_2,
   output wire o_phase_out_3,
   output wire o_phase_out_4,
   output reg o_auxiliary_plane_pwm,
   output reg o_auxiliary_plane_oe,
   output wire [7:0] o_core_ref,
   output wire [7:0] o_aux_ref,
   output reg o_parallel_code_mode,
   output wire o_serial_clk,
   output wire o_serial_data
);

   // Pin synchronisers
   reg [5:0] code_s1;
   reg [5:0] code_s2;
   reg en_s1;
   reg en_s2;
   reg en_s3;
   reg pok_s1;
   reg pok_s2;
   reg fix_n_s1;
   reg fix_n_s2;

   // Software registers
   reg [31:0] ctrl;
   reg [7:0] sw_core_target;
   reg [7:0] sw_aux_target;
   reg [15:0] slew_cycles;
   reg [15:0] period_cycles;
   reg [15:0] duty_cycles;

   // Captured at enable rise
   reg [1:0] boot_code;

   // Registered serial pin roles
   reg serial_clk;
   reg serial_data;

   // Auxiliary timebase
   reg [16:0] aux_cnt;
   wire [16:0] aux_period;
   wire aux_run;

   reg [7:0] core_target;
   reg [7:0] aux_target;
   wire en_rise;
   wire running;
   wire fixed_active;
   wire core_busy;
   wire aux_busy;
   wire [3:0] phases;
   wire [1:0] phase_sel;
   wire wr_access;
   wire addr_ok;

   // Parallel code to reference, 12.5 mV units
   function [7:0] par_decode;
      input [5:0] code;
      begin
         if (code < `PAR_HALF) begin
            // RL6 25 mV steps
            par_decode = `REF_HI_BASE - {1'b0, code, 1'b0};
         end else begin
            // RL7 12.5 mV steps
            par_decode = `REF_LO_BASE - {2'b00, code};
         end
      end
   endfunction

   // Two-bit static code to reference
   function [7:0] fix_decode;
      input [1:0] cd;
      begin
         case (cd)
            2'b00: fix_decode = `FIX_REF_00;
            2'b01: fix_decode = `FIX_REF_01;
            2'b10: fix_decode = `FIX_REF_10;
            default: fix_decode = `FIX_REF_11;
         endcase
      end
   endfunction

   // Register address decode
   function known_addr;
      input [7:0] a;
      begin
         known_addr = (a == `REG_CTRL) || (a == `REG_TARGET) || (a == `REG_SLEW) ||
                      (a == `REG_TIMING) || (a == `REG_STATUS);
      end
   endfunction

   // Two flip-flops on every pin, and a third on enable for edge detection
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         code_s1 <= 6'h00;
         code_s2 <= 6'h00;
         en_s1 <= 1'b0;
         en_s2 <= 1'b0;
         en_s3 <= 1'b0;
         pok_s1 <= 1'b0;
         pok_s2 <= 1'b0;
         fix_n_s1 <= 1'b1;
         fix_n_s2 <= 1'b1;
      end else begin
         code_s1 <= i_parallel_code_bus;
         code_s2 <= code_s1;
         en_s1 <= i_enable;
         en_s2 <= en_s1;
         en_s3 <= en_s2;
         pok_s1 <= i_host_power_ok;
         pok_s2 <= pok_s1;
         fix_n_s1 <= i_fixed_debug_select_n;
         fix_n_s2 <= fix_n_s1;
      end
   end

   assign en_rise = en_s2 & ~en_s3;
   assign running = en_s2;

   // RL1 mode capture
   // RL16 mode held
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_parallel_code_mode <= 1'b0;
         boot_code <= 2'b00;
      end else if (en_rise) begin
         o_parallel_code_mode <= code_s2[`PIN_MODE_SENSE];
         boot_code <= {code_s2[`PIN_SERIAL_CLK], code_s2[`PIN_SERIAL_DATA]};
      end
   end

   // RL5 serial pin roles, held at zero in parallel mode
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         serial_clk <= 1'b0;
         serial_data <= 1'b0;
      end else begin
         serial_clk <= ~o_parallel_code_mode & code_s2[`PIN_SERIAL_CLK];
         serial_data <= ~o_parallel_code_mode & code_s2[`PIN_SERIAL_DATA];
      end
   end

   assign o_serial_clk = serial_clk;
   assign o_serial_data = serial_data;

   // RL15 fixed debug while select low
   assign fixed_active = running & ~o_parallel_code_mode & ~fix_n_s2;

   // Target selection by mode
   always @* begin
      core_target = `REF_OFF;
      aux_target = `REF_OFF;
      if (!running) begin
         core_target = `REF_OFF;
      end else if (o_parallel_code_mode) begin
         // RL2 core from code bus
         // RL4 power ok not consulted
         core_target = par_decode(code_s2);
      end else if (fixed_active) begin
         // RL12 static pin pair
         // RL14 fixed voltage table
         core_target = fix_decode({code_s2[`PIN_SERIAL_CLK], code_s2[`PIN_SERIAL_DATA]});
         aux_target = core_target;
      end else if (!pok_s2) begin
         // Boot level until host reports power ok
         core_target = fix_decode(boot_code);
         aux_target = core_target;
      end else begin
         core_target = sw_core_target;
         aux_target = sw_aux_target;
      end
      if (!ctrl[`CTRL_AUX_EN]) begin
         aux_target = `REF_OFF;
      end
   end

   // RL13 slewed core reference
   ref_slew u_core_slew (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_target(core_target),
      .i_step_cycles(slew_cycles),
      .o_ref(o_core_ref),
      .o_busy(core_busy)
   );

   // RL13 slewed auxiliary reference
   ref_slew u_aux_slew (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_target(aux_target),
      .i_step_cycles(slew_cycles),
      .o_ref(o_aux_ref),
      .o_busy(aux_busy)
   );

   assign phase_sel = ctrl[`CTRL_PHASE_MSB:`CTRL_PHASE_LSB];

   // Staggered core phases
   phase_gen u_phase (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_run(running),
      .i_phase_sel(phase_sel),
      .i_period(period_cycles),
      .i_duty(duty_cycles),
      .o_phase(phases)
   );

   assign o_phase_out_1 = phases[0];
   assign o_phase_out_2 = phases[1];
   assign o_phase_out_3 = phases[2];
   assign o_phase_out_4 = phases[3];

   // RL3 auxiliary idle in parallel mode
   assign aux_run = running & ~o_parallel_code_mode & ctrl[`CTRL_AUX_EN];
   // RL11 period is 1.25 of core
   assign aux_period = {1'b0, period_cycles} + {3'b000, period_cycles[15:2]};

   // Free-running auxiliary timebase and output
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aux_cnt <= 17'h0_0000;
         o_auxiliary_plane_pwm <= 1'b0;
         o_auxiliary_plane_oe <= 1'b0;
      end else begin
         o_auxiliary_plane_oe <= aux_run;
         if (!aux_run || aux_cnt + 17'h0_0001 >= aux_period) begin
            aux_cnt <= 17'h0_0000;
         end else begin
            aux_cnt <= aux_cnt + 17'h0_0001;
         end
         o_auxiliary_plane_pwm <= aux_run & (aux_cnt < {1'b0, duty_cycles});
      end
   end

   // Bus slave: zero wait states, error on unmapped addresses
   assign o_pready = 1'b1;
   assign addr_ok = known_addr(i_paddr);
   assign o_pslverr = i_psel & i_penable & ~addr_ok;
   assign wr_access = i_psel & i_penable & i_pwrite & addr_ok;

   // Register writes
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl <= `CTRL_RESET;
         sw_core_target <= `REF_OFF;
         sw_aux_target <= `REF_OFF;
         slew_cycles <= `SLEW_STEP_CYC;
         period_cycles <= `PHASE_PERIOD_CYC;
         duty_cycles <= `PHASE_DUTY_CYC;
      end else if (wr_access) begin
         case (i_paddr)
            `REG_CTRL: begin
               ctrl <= {29'h0000_0000, i_pwdata[2:0]};
            end
            `REG_TARGET: begin
               sw_core_target <= i_pwdata[7:0];
               sw_aux_target <= i_pwdata[15:8];
            end
            `REG_SLEW: begin
               slew_cycles <= i_pwdata[15:0];
            end
            `REG_TIMING: begin
               period_cycles <= i_pwdata[15:0];
               duty_cycles <= i_pwdata[31:16];
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   // Read data loaded in the setup cycle
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            `REG_CTRL: o_prdata <= ctrl;
            `REG_TARGET: o_prdata <= {16'h0000, sw_aux_target, sw_core_target};
            `REG_SLEW: o_prdata <= {16'h0000, slew_cycles};
            `REG_TIMING: o_prdata <= {duty_cycles, period_cycles};
            `REG_STATUS: o_prdata <= {8'h00, o_aux_ref, o_core_ref, 3'b000,
                                      aux_busy, core_busy, running, fixed_active,
                                      o_parallel_code_mode};
            default: o_prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule
`default_nettype wire

// file: verif/vid_mode_select_decode_monitor.sv
`default_nettype none
module vid_mode_select_decode_monitor (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pslverr,
   input wire logic i_enable,
   input wire logic o_phase_out_2,
   input wire logic o_phase_out_4,
   input wire logic o_auxiliary_plane_pwm,
   input wire logic o_auxiliary_plane_oe,
   input wire logic [7:0] o_core_ref,
   input wire logic [7:0] o_aux_ref,
   input wire logic o_parallel_code_mode,
   input wire logic o_serial_clk,
   input wire logic o_serial_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] sel;
   logic unmapped;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Phase count as last written to the control register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         sel <= 2'h2;
      else if (i_psel && i_penable && i_pwrite && i_paddr == 8'h00)
         sel <= i_pwdata[1:0];
   end
   // Decode of places with no register
   assign unmapped = (i_paddr > 8'h10) || (i_paddr[1:0] != 2'h0);
   chk_aux_hiz: assert property (
      o_parallel_code_mode && $past(o_parallel_code_mode) |-> !o_auxiliary_plane_oe
      && !o_auxiliary_plane_pwm) else $error("aux plane active in parallel mode");
   chk_serial_gate: assert property (
      o_parallel_code_mode && $past(o_parallel_code_mode) |-> !o_serial_clk && !o_serial_data)
      else $error("serial pins passed in parallel mode");
   chk_mode_hold: assert property (
      $changed(o_parallel_code_mode) |-> $past(i_enable, 2) && !$past(i_enable, 6))
      else $error("mode changed without enable rise");
   chk_core_slew: assert property (
      $changed(o_core_ref) |-> o_core_ref == $past(o_core_ref) + 8'h01
      || o_core_ref == $past(o_core_ref) - 8'h01) else $error("core ref jumped");
   chk_aux_slew: assert property (
      $changed(o_aux_ref) |-> o_aux_ref == $past(o_aux_ref) + 8'h01
      || o_aux_ref == $past(o_aux_ref) - 8'h01) else $error("aux ref jumped");
   chk_two_phase: assert property (
      (sel == 2'h0) [*4] |-> !o_phase_out_2 && !o_phase_out_4)
      else $error("unused phase driven in two phase");
   chk_three_phase: assert property (
      (sel == 2'h1) [*4] |-> !o_phase_out_4) else $error("phase 4 driven in three phase");
   chk_bus_error: assert property (
      i_psel && i_penable |-> o_pslverr == unmapped) else $error("bus error flag wrong");
endmodule
bind vid_mode_select_decode vid_mode_select_decode_monitor mon (.i_clk, .i_rst_b, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pslverr, .i_enable, .o_phase_out_2,
   .o_phase_out_4, .o_auxiliary_plane_pwm, .o_auxiliary_plane_oe, .o_core_ref, .o_aux_ref,
   .o_parallel_code_mode, .o_serial_clk, .o_serial_data);
`default_nettype wire

// file: verif/host_cpu.sv
`default_nettype none
// Host side: enable, code pins, power ok and fixed select jumper
module host_cpu (
   input wire logic i_clk,
   output logic o_enable,
   output logic [5:0] o_code,
   output logic o_power_ok,
   output logic o_fixed_n
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_enable = 1'b0;
      o_code = 6'h00;
      o_power_ok = 1'b0;
      o_fixed_n = 1'b1;
   end
   task automatic start(input logic [5:0] c);
      @(posedge i_clk);
      o_code <= c;
      o_power_ok <= 1'b0;
      o_fixed_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_enable <= 1'b1;
   endtask
   task automatic stop();
      @(posedge i_clk);
      o_enable <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic pins(input logic [5:0] c, input logic ok, input logic fn);
      @(posedge i_clk);
      o_code <= c;
      o_power_ok <= ok;
      o_fixed_n <= fn;
   endtask
endmodule
`default_nettype wire

// file: verif/test_vid_mode_select_decode.sv
`default_nettype none
module test_vid_mode_select_decode;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_b, psel, penable, pwrite, en, pok, fix_n, e;
   logic pready, pslverr, aux_pwm, aux_oe, par, sclk, sdata;
   logic [7:0] paddr, core_ref, aux_ref;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] code;
   logic [3:0] ph;
   int err_count, compares, c;
   logic [7:0] addrs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
   logic [31:0] rstv[5] = '{32'h0000_0006, 32'h0, 32'h0000_00C8, 32'h0064_0190, 32'h0};
   logic [5:0] pcode[5] = '{6'h00, 6'h1F, 6'h20, 6'h2A, 6'h3F};
   logic [7:0] pexp[5] = '{8'h7C, 8'h3E, 8'h3D, 8'h33, 8'h1E};
   int pb[3] = '{2, 1, 3};
   int pg[3] = '{24, 16, 36};
   host_cpu host (.i_clk(clk), .o_enable(en), .o_code(code), .o_power_ok(pok),
      .o_fixed_n(fix_n));
   vid_mode_select_decode DUT (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_enable(en),
      .i_parallel_code_bus(code), .i_host_power_ok(pok), .i_fixed_debug_select_n(fix_n),
      .o_phase_out_1(ph[0]), .o_phase_out_2(ph[1]), .o_phase_out_3(ph[2]),
      .o_phase_out_4(ph[3]), .o_auxiliary_plane_pwm(aux_pwm), .o_auxiliary_plane_oe(aux_oe),
      .o_core_ref(core_ref), .o_aux_ref(aux_ref), .o_parallel_code_mode(par),
      .o_serial_clk(sclk), .o_serial_data(sdata));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   // One APB transfer; read data and error flag kept in q and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         report_and_stop();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Waits for a reference to reach its target
   task automatic wait_ref(input logic aux, input logic [7:0] exp);
      int n;
      for (n = 0; n < 1000 && (aux ? aux_ref : core_ref) !== exp; n++)
         @(negedge clk);
      chk(aux ? aux_ref : core_ref, exp);
      if (n >= 1000)
         report_and_stop();
   endtask
   // Cycles until the next rising edge of output b (4 is aux)
   task automatic wrise(input int b, output int n);
      logic [4:0] s;
      logic last;
      last = 1'b1;
      for (n = 1; n <= 300; n++) begin
         @(negedge clk);
         s = {aux_pwm, ph};
         if (s[b] && !last)
            return;
         last = s[b];
      end
      err_count++;
      report_and_stop();
   endtask
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      compares = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values and an unmapped place
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, addrs[i], 32'h0);
         chk(q, rstv[i]);
         chk(e, i == 4);
      end
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h0C, 32'h000A_0030);
      // Parallel boot, then codes over both halves with power ok and select ignored
      host.start(6'h02);
      wait_ref(1'b0, 8'h78);
      chk(par, 1);
      for (int i = 0; i < 5; i++) begin
         host.pins(pcode[i], i[0], i[1]);
         wait_ref(1'b0, pexp[i]);
      end
      chk(aux_oe, 0);
      // Phase counts and spacing
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, 8'h00, 32'h0000_0004 | s);
         repeat (60) @(posedge clk);
         wrise(0, c);
         wrise(pb[s], c);
         chk(c, pg[s]);
      end
      host.stop();
      chk(par, 1);
      // Serial boot with power ok low
      host.start(6'h08);
      wait_ref(1'b0, 8'h60);
      chk(par, 0);
      chk({sclk, sdata}, 2'b01);
      wrise(4, c);
      wrise(4, c);
      chk(c, 60);
      chk(aux_oe, 1);
      // Fixed select, unused pins and mode pin toggled
      for (int i = 0; i < 4; i++) begin
         host.pins({2'b11, i[0], i[1], 2'b11}, i[0], 1'b0);
         wait_ref(1'b0, 8'h70 - 8'h10 * i);
         wait_ref(1'b1, 8'h70 - 8'h10 * i);
      end
      apb(1'b1, 8'h04, 32'h0000_2030);
      host.pins(6'h00, 1'b1, 1'b1);
      wait_ref(1'b0, 8'h30);
      wait_ref(1'b1, 8'h20);
      host.pins(6'h31, 1'b1, 1'b1);
      repeat (30) @(posedge clk);
      chk(core_ref, 8'h30);
      chk(par, 0);
      // Status word with settled references, then auxiliary plane switched off
      apb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0020_3004);
      apb(1'b1, 8'h00, 32'h0000_0003);
      wait_ref(1'b1, 8'h00);
      chk(aux_oe, 0);
      wrise(0, c);
      wrise(3, c);
      chk(c, 36);
      report_and_stop();
   end
endmodule
`default_nettype wire
